// file: rtl/opdec_cfg.svh
// constants for the upper opcode decoder
`ifndef OPDEC_CFG_SVH
`define OPDEC_CFG_SVH
`define RESET_VECTOR 13'h0000
`define TRAP_VECTOR 13'h0001
`define IRQ_VECTOR 13'h0008
`define TRAP_WORD 13'h1e01
`define OP_ADD 5'h03
`define OP_MOV 5'h04
`define OP_DEC 5'h05
`define OP_ROT 5'h06
`define OP_NIB 5'h07
`define OP_ORK 5'h19
`define OP_ANDK 5'h1a
`define OP_XORK 5'h1b
`define OP_RETK 5'h1c
`define OP_PAGE 5'h1e
`define ACC_RESET 8'h00
`define BANK_SEL_HI 7
`define BANK_SEL_LO 6
`define FLAG_Z 2
`define FLAG_DC 1
`define FLAG_C 0
`endif

// file: rtl/opdec_pkg.sv
// types for the upper opcode decoder
package opdec_pkg;
    // core state, one flop group
    typedef struct packed {
        logic [12:0] pc;
        logic [7:0] acc;
        logic [2:0] flags;
        logic [2:0] page;
        logic skip;
        logic [12:0] ret_addr;
        logic [7:0] wr_data;
        logic [7:0] wr_addr;
        logic wr_en;
        logic push;
        logic pop;
    } state_type;
endpackage

// file: rtl/risc_opcode_decode_upper.sv
// execute stage for the upper part of a 13-bit instruction set
// *****************************************************************
// *****************************************************************
`timescale 1ns/100ps
`include "opdec_cfg.svh"
module risc_opcode_decode_upper #(
    parameter int INSTR_W = 13
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // instruction from program memory
    input wire logic [INSTR_W-1:0] INSTR_I,
    input wire logic INSTR_VALID_I,
    // operand read data and bank select register value
    input wire logic [7:0] REG_RDATA_I,
    input wire logic [7:0] BANK_SEL_I,
    // stack top value
    input wire logic [12:0] STACK_TOP_I,
    // fetch address
    output logic [12:0] PC_O,
    // register write port
    output logic REG_WE_O,
    output logic [7:0] REG_WADDR_O,
    output logic [7:0] REG_WDATA_O,
    // stack control
    output logic PUSH_O,
    output logic POP_O,
    output logic [12:0] PUSH_DATA_O,
    // architectural state
    output logic [7:0] ACC_O,
    output logic [2:0] FLAGS_O,
    output logic [2:0] PAGE_O,
    output logic SKIP_O
);
    // *************************************************************
    // state
    // *************************************************************
    opdec_pkg::state_type state_reg; // all flops
    opdec_pkg::state_type state_next; // next value
    // the skip bit lives in the state so that a taken skip cancels exactly
    // one following instruction, whatever that instruction encodes
    // the hardware interrupt vector is reserved; there is no request input here

    // zero test used by several operations
    // one shared test keeps every zero flag update alike
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction

    // combinational address of the current operand
    // the bank bits are read live, so a bank change applies
    // to the very next register operand
    logic [7:0] reg_addr; // bank plus designator
    assign reg_addr = {BANK_SEL_I[`BANK_SEL_HI:`BANK_SEL_LO], INSTR_I[5:0]};

    // *************************************************************
    // next state
    // *************************************************************
    // one pass per valid instruction: discarded word first, then the trap
    // word, then branches, then the opcode groups; register results are
    // steered to the accumulator or the write port at the end
    // strobes default low so each lasts exactly one cycle
    always_comb begin
        logic [8:0] sum;
        logic [4:0] lsum;
        logic [7:0] res;
        logic [4:0] op;
        logic to_reg;
        sum = 9'h000;
        lsum = 5'h00;
        res = 8'h00;
        op = INSTR_I[12:8];
        to_reg = INSTR_I[6];
        state_next = state_reg;
        state_next.wr_en = 1'b0;
        state_next.push = 1'b0;
        state_next.pop = 1'b0;
        state_next.wr_addr = reg_addr;
        if (INSTR_VALID_I) begin
            state_next.pc = state_reg.pc + 13'h0001;
            state_next.ret_addr = state_reg.pc + 13'h0001;
            state_next.skip = 1'b0;
            if (state_reg.skip) begin
                // discarded instruction, nothing else
                state_next.skip = 1'b0;
            end else if (INSTR_I == `TRAP_WORD) begin
                state_next.push = 1'b1;
                state_next.pc = `TRAP_VECTOR;
            end else if (INSTR_I[12:11] == 2'b10) begin
                // call or jump
                state_next.push = ~INSTR_I[10];
                state_next.pc = {state_reg.page, INSTR_I[9:0]};
            end else begin
                // literal operations write the accumulator inside the case
                unique case (op)
                    `OP_ADD: begin
                        if (INSTR_I[7]) begin
                            sum = {1'b0, state_reg.acc} + {1'b0, REG_RDATA_I};
                            lsum = {1'b0, state_reg.acc[3:0]} + {1'b0, REG_RDATA_I[3:0]};
                            res = sum[7:0];
                            state_next.flags = {is_zero(res), lsum[4], sum[8]};
                        end
                    end
                    `OP_MOV: begin
                        if (!INSTR_I[7]) begin
                            res = REG_RDATA_I;
                            state_next.flags[`FLAG_Z] = is_zero(res);
                        end
                    end
                    `OP_DEC: begin
                        if (INSTR_I[7]) begin
                            res = REG_RDATA_I - 8'h01;
                            state_next.skip = is_zero(res);
                        end
                    end
                    `OP_ROT: begin
                        // old carry enters at the far end, the leaving bit becomes carry
                        if (INSTR_I[7]) begin
                            res = {REG_RDATA_I[6:0], state_reg.flags[`FLAG_C]};
                            state_next.flags[`FLAG_C] = REG_RDATA_I[7];
                        end else begin
                            res = {state_reg.flags[`FLAG_C], REG_RDATA_I[7:1]};
                            state_next.flags[`FLAG_C] = REG_RDATA_I[0];
                        end
                    end
                    `OP_NIB: begin
                        // increment with skip shares this opcode with the nibble exchange
                        if (INSTR_I[7]) begin
                            res = REG_RDATA_I + 8'h01;
                            state_next.skip = is_zero(res);
                        end else begin
                            res = {REG_RDATA_I[3:0], REG_RDATA_I[7:4]};
                        end
                    end
                    `OP_ORK, `OP_ANDK, `OP_XORK: begin
                        if (op == `OP_ORK) begin
                            res = state_reg.acc | INSTR_I[7:0];
                        end else if (op == `OP_ANDK) begin
                            res = state_reg.acc & INSTR_I[7:0];
                        end else begin
                            res = state_reg.acc ^ INSTR_I[7:0];
                        end
                        state_next.acc = res;
                        state_next.flags[`FLAG_Z] = is_zero(res);
                    end
                    `OP_RETK: begin
                        state_next.acc = INSTR_I[7:0];
                        state_next.pop = 1'b1;
                        // return address is the stack top presented this cycle
                        state_next.pc = STACK_TOP_I;
                    end
                    `OP_PAGE: begin
                        // only the low three literal bits select the page
                        if (INSTR_I[7:4] == 4'h8) begin
                            state_next.page = INSTR_I[2:0];
                        end
                    end
                    default: begin
                        // lower opcodes handled elsewhere
                    end
                endcase
                // destination select for register operand group
                // bit 6 set picks the register, clear picks the accumulator
                // forms owned by other blocks leave both untouched
                if ((op >= `OP_ADD) && (op <= `OP_NIB)) begin
                    if ((op == `OP_ADD || op == `OP_DEC) && !INSTR_I[7]) begin
                        // lower forms of these opcodes handled elsewhere
                    end else if (op == `OP_MOV && INSTR_I[7]) begin
                        // complement forms handled elsewhere
                    end else if (to_reg) begin
                        state_next.wr_en = 1'b1;
                        state_next.wr_data = res;
                    end else begin
                        state_next.acc = res;
                    end
                end
            end
        end
    end

    // *************************************************************
    // registers
    // *************************************************************
    // asynchronous clear to constants only, then a plain register update
    // reset puts fetch at the reset vector with every strobe low
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_reg <= '0;
            state_reg.pc <= `RESET_VECTOR;
            state_reg.acc <= `ACC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    // each port is a field of the one state register, no logic between
    assign PC_O = state_reg.pc;
    assign REG_WE_O = state_reg.wr_en;
    assign REG_WADDR_O = state_reg.wr_addr;
    assign REG_WDATA_O = state_reg.wr_data;
    assign PUSH_O = state_reg.push;
    assign POP_O = state_reg.pop;
    assign PUSH_DATA_O = state_reg.ret_addr;
    assign ACC_O = state_reg.acc;
    assign FLAGS_O = state_reg.flags;
    assign PAGE_O = state_reg.page;
    assign SKIP_O = state_reg.skip;
endmodule

// file: verif/opdec_chk.sv
// assertion checker for the upper opcode decoder
`timescale 1ns/100ps
module opdec_chk #(parameter int INSTR_W = 13) (
    // clock, reset and inputs
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic INSTR_VALID_I,
    input wire logic [INSTR_W-1:0] INSTR_I,
    input wire logic [7:0] REG_RDATA_I,
    input wire logic [7:0] BANK_SEL_I,
    input wire logic [12:0] STACK_TOP_I,
    // outputs under watch
    input wire logic [12:0] PC_O,
    input wire logic REG_WE_O,
    input wire logic [7:0] REG_WADDR_O,
    input wire logic [7:0] REG_WDATA_O,
    input wire logic PUSH_O,
    input wire logic POP_O,
    input wire logic [12:0] PUSH_DATA_O,
    input wire logic [7:0] ACC_O,
    input wire logic [2:0] FLAGS_O,
    input wire logic [2:0] PAGE_O,
    input wire logic SKIP_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // an instruction that really executes, not one being discarded
    wire go = INSTR_VALID_I && !SKIP_O;
    wire [4:0] op = INSTR_I[12:8];
    wire [1:0] md = INSTR_I[7:6];
    chk_add_acc: assert property (go && op == 5'h03 && md == 2'b10
        |=> ACC_O == 8'($past(ACC_O) + $past(REG_RDATA_I))) else $error("add sum wrong");
    chk_write_addr: assert property (go && op == 5'h03 && md == 2'b11 |=> REG_WE_O
        && REG_WADDR_O == {$past(BANK_SEL_I[7:6]), $past(INSTR_I[5:0])}) else $error("waddr");
    chk_dec_skip: assert property (go && op == 5'h05 && INSTR_I[7]
        |=> SKIP_O == ($past(REG_RDATA_I) == 8'h01) && $stable(FLAGS_O)) else $error("dec skip");
    chk_rot_right: assert property (go && op == 5'h06 && md == 2'b00
        |=> ACC_O == {$past(FLAGS_O[0]), $past(REG_RDATA_I[7:1])}) else $error("rot right");
    chk_swap_acc: assert property (go && op == 5'h07 && md == 2'b00
        |=> ACC_O == {$past(REG_RDATA_I[3:0]), $past(REG_RDATA_I[7:4])}) else $error("swap");
    chk_jump_page: assert property (go && INSTR_I[12:10] == 3'b101
        |=> !PUSH_O && PC_O == {$past(PAGE_O), $past(INSTR_I[9:0])}) else $error("jump");
    chk_trap_vec: assert property (go && INSTR_I == 13'h1e01 |=> PUSH_O && PC_O == 13'h0001
        && PUSH_DATA_O == 13'($past(PC_O) + 1)) else $error("trap");
    chk_ret_lit: assert property (go && op == 5'h1c |=> POP_O
        && ACC_O == $past(INSTR_I[7:0]) && PC_O == $past(STACK_TOP_I)) else $error("ret lit");
    chk_skip_nop: assert property (INSTR_VALID_I && SKIP_O |=> !REG_WE_O
        && !PUSH_O && !POP_O && $stable(ACC_O) && $stable(FLAGS_O)) else $error("skip nop");
endmodule
bind risc_opcode_decode_upper opdec_chk #(.INSTR_W(INSTR_W)) u_chk (.CLK_I(CLK_I),
    .RST_B_I(RST_B_I), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I),
    .REG_RDATA_I(REG_RDATA_I), .BANK_SEL_I(BANK_SEL_I), .STACK_TOP_I(STACK_TOP_I),
    .PC_O(PC_O), .REG_WE_O(REG_WE_O), .REG_WADDR_O(REG_WADDR_O), .REG_WDATA_O(REG_WDATA_O),
    .PUSH_O(PUSH_O), .POP_O(POP_O), .PUSH_DATA_O(PUSH_DATA_O), .ACC_O(ACC_O),
    .FLAGS_O(FLAGS_O), .PAGE_O(PAGE_O), .SKIP_O(SKIP_O));

// file: verif/prog_mem_model.sv
// program memory model that feeds instruction words
`timescale 1ns/100ps
module prog_mem_model (
    input wire logic [12:0] addr_i,
    output logic [12:0] instr_o
);
    logic [12:0] rom [0:255]; // program words, placed by the bench
    initial for (int i = 0; i < 256; i++) rom[i] = 13'h0000;
    assign instr_o = rom[addr_i[7:0]]; // combinational read of the fetch address
endmodule

// file: verif/risc_opcode_decode_upper_bench.sv
// self-checking bench for the upper opcode decoder
`timescale 1ns/100ps
module risc_opcode_decode_upper_bench;
    logic clk = 0, rst_b = 0, valid = 0, we, push, pop, skip;
    logic [7:0] rdata = 8'h00, bank = 8'h80, waddr, wdata, acc;
    logic [12:0] stack = 13'h0123, instr, pc, pdata, pc_e = 13'h0000;
    logic [2:0] flags, page;
    int bad_count = 0, n_tests = 0;
    prog_mem_model MEM (.addr_i(pc), .instr_o(instr));
    risc_opcode_decode_upper DUT (.CLK_I(clk), .RST_B_I(rst_b), .INSTR_I(instr),
        .INSTR_VALID_I(valid), .REG_RDATA_I(rdata), .BANK_SEL_I(bank), .STACK_TOP_I(stack),
        .PC_O(pc), .REG_WE_O(we), .REG_WADDR_O(waddr), .REG_WDATA_O(wdata), .PUSH_O(push),
        .POP_O(pop), .PUSH_DATA_O(pdata), .ACC_O(acc), .FLAGS_O(flags), .PAGE_O(page),
        .SKIP_O(skip));
    task cmp(input logic [12:0] got, input logic [12:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one instruction: fetch address, then accumulator and flags after it
    task step(input logic [12:0] w, input logic [7:0] r, a, input logic [2:0] f);
        cmp(pc, pc_e);
        MEM.rom[pc[7:0]] = w;
        rdata = r;
        valid = 1'b1;
        @(posedge clk);
        #1;
        pc_e = pc_e + 13'h0001;
        cmp(acc, a);
        cmp(flags, f);
    endtask
    task t_add;
        step(13'h19f8, 8'h00, 8'hf8, 3'h0);
        step(13'h0385, 8'h08, 8'h00, 3'h7);
        cmp(we, 1'b0);
        step(13'h03c5, 8'h11, 8'h00, 3'h0);
        cmp(we, 1'b1);
        cmp(waddr, 8'h85);
        cmp(wdata, 8'h11);
    endtask
    task t_rot;
        step(13'h0600, 8'h03, 8'h01, 3'h1);
        bank = 8'h40;
        step(13'h06c2, 8'h80, 8'h01, 3'h1);
        cmp(wdata, 8'h01);
        cmp(waddr, 8'h42);
        step(13'h0640, 8'h00, 8'h01, 3'h0);
        cmp(wdata, 8'h80);
        step(13'h0680, 8'h01, 8'h02, 3'h0);
    endtask
    task t_nib;
        step(13'h0700, 8'h3c, 8'hc3, 3'h0);
        step(13'h0741, 8'ha5, 8'hc3, 3'h0);
        cmp(wdata, 8'h5a);
        step(13'h0400, 8'h00, 8'h00, 3'h4);
        step(13'h0443, 8'h77, 8'h00, 3'h0);
        cmp(wdata, 8'h77);
    endtask
    task t_skip;
        step(13'h05c0, 8'h02, 8'h00, 3'h0);
        cmp(skip, 1'b0);
        step(13'h0580, 8'h01, 8'h00, 3'h0);
        step(13'h19ff, 8'h00, 8'h00, 3'h0);
        step(13'h07c4, 8'hff, 8'h00, 3'h0);
        cmp(skip, 1'b1);
        step(13'h1c33, 8'h00, 8'h00, 3'h0);
        cmp(pop, 1'b0);
    endtask
    task t_lit;
        step(13'h19f0, 8'h00, 8'hf0, 3'h0);
        step(13'h1a0f, 8'h00, 8'h00, 3'h4);
        step(13'h0780, 8'h41, 8'h42, 3'h4);
        cmp(we, 1'b0);
        cmp(skip, 1'b0);
        step(13'h1b18, 8'h00, 8'h5a, 3'h0);
    endtask
    task t_branch;
        step(13'h1155, 8'h00, 8'h5a, 3'h0);
        cmp(pdata, pc_e);
        cmp(push, 1'b1);
        pc_e = 13'h0155;
        step(13'h16aa, 8'h00, 8'h5a, 3'h0);
        cmp(push, 1'b0);
        pc_e = 13'h02aa;
        step(13'h1e85, 8'h00, 8'h5a, 3'h0);
        step(13'h1410, 8'h00, 8'h5a, 3'h0);
        cmp(page, 3'h5);
        pc_e = 13'h1410;
        step(13'h1e01, 8'h00, 8'h5a, 3'h0);
        cmp(pdata, pc_e);
        cmp(push, 1'b1);
        pc_e = 13'h0001;
        step(13'h1c33, 8'h00, 8'h33, 3'h0);
        pc_e = 13'h0123;
        cmp(pc, pc_e);
        cmp(pop, 1'b1);
    endtask
    // mid-run reset clears state at once, fetch restarts at the reset vector
    task t_reset;
        rst_b = 1'b0;
        #1;
        cmp(pc, 13'h0000);
        cmp(page, 3'h0);
        cmp(acc, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        pc_e = 13'h0000;
        step(13'h19a5, 8'h00, 8'ha5, 3'h0);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #20000;
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_add;
        t_rot;
        t_nib;
        t_skip;
        t_lit;
        t_branch;
        t_reset;
        finish_test;
    end
endmodule
